// File: design/sapslv_params.svh
// Purpose: Constants of the serial audio slave port
// Assumes: Included by the port module only
// Notes:   Counts are in bit clocks; the output divider is in cycles of the 200 MHz core clock
`ifndef SAPSLV_PARAMS_SVH
`define SAPSLV_PARAMS_SVH
// Kept sample width; longer I2S words lose their LSBs, longer LSB-justified words their MSBs
`define SAPSLV_KEEP_BITS     24
// Word size selector codes
`define SAPSLV_WSZ_16        2'h0
`define SAPSLV_WSZ_18        2'h1
`define SAPSLV_WSZ_20        2'h2
`define SAPSLV_WSZ_24        2'h3
// Most bit clocks counted in one word select half
`define SAPSLV_MAX_BCK       9'h100
// Output framing: bits per channel slot and per frame
`define SAPSLV_SLOT_BITS     6'h20
`define SAPSLV_FRAME_BITS    7'h40
// Core clock cycles per half period of the output bit clock
`define SAPSLV_OUT_HALF_DIV  8
`endif

// File: design/sapslv_pkg.sv
// Purpose: Types of the serial audio slave port
// Assumes: Nothing
// Notes:   Channel 2k is left, 2k+1 is right of serial input k
package sapslv_pkg;
  typedef logic [23:0] sapslv_sample_type;
  typedef logic [7:0][23:0] sapslv_frame_type;
  typedef enum logic {SAPSLV_I2S, SAPSLV_LSBJ} sapslv_format_type;
endpackage

// File: design/sapslv_top.sv
// Purpose: Slave serial audio input port, four stereo inputs or one coax source,
//          plus a four-lane serial output driven by this block
// Assumes: Pins are asynchronous to clock; coax receivers decode off-block
// Notes:   Input bit clock must stay well below clock/4 to be sampled
// How it works
// [R1] The external source drives bit clock and word select; this block only samples them.
// [R2] Each link is one data line, one bit clock line and one word select line.
// [R3] Both I2S and LSB-justified framing are decoded, at 16, 18, 20 or 24 bits.
// [R4] The source keeps its sample rate between 32 kHz and 96 kHz.
// [R5] Words longer than 24 bits keep their 24 MSBs and drop the rest; LSB-justified decoding keeps their 24 LSBs instead.
// [R6] The source gives at most 256 bit clocks per word select period.
// [R7] In LSB-justified framing the source keeps word select at 50% duty.
// [R8] Serial mode takes four stereo inputs on one shared bit clock and word select.
// [R9] Coax mode takes one of two coax receivers as the only stereo source.
// [R10] One configuration bit chooses serial mode or coax mode.
// [R11] Configuration bits choose framing and word size before data is decoded.
// [R12] Coax receiver a shares the pin of serial input b, receiver b that of input c.
// [R13] The four serial outputs share one word select and one bit clock made here.
// [R14] I2S data is MSB first one bit clock after each word select edge, low is left.
// [R15] LSB-justified data ends with its LSB on the last bit clock before the edge.
`timescale 1ns/1ps
`include "sapslv_params.svh"
module sapslv_top #(
  parameter int OUT_HALF_DIV = `SAPSLV_OUT_HALF_DIV
) (
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  input  wire logic                         port_bit_clock,
  input  wire logic                         port_word_select,
  input  wire logic [3:0]                   serial_in,
  input  wire logic                         cfg_coax_mode,
  input  wire logic                         cfg_coax_sel,
  input  wire sapslv_pkg::sapslv_format_type cfg_format,
  input  wire logic [1:0]                   cfg_word_size,
  input  wire sapslv_pkg::sapslv_sample_type coax_a_left,
  input  wire sapslv_pkg::sapslv_sample_type coax_a_right,
  input  wire logic                         coax_a_valid,
  input  wire sapslv_pkg::sapslv_sample_type coax_b_left,
  input  wire sapslv_pkg::sapslv_sample_type coax_b_right,
  input  wire logic                         coax_b_valid,
  output logic                              coax_receiver_a,
  output logic                              coax_receiver_b,
  output sapslv_pkg::sapslv_frame_type      rx_frame,
  output logic                              rx_frame_valid,
  output sapslv_pkg::sapslv_sample_type     stream_dac_left,
  output sapslv_pkg::sapslv_sample_type     stream_dac_right,
  input  wire sapslv_pkg::sapslv_frame_type tx_frame,
  output logic                              serial_out_a,
  output logic                              serial_out_b,
  output logic                              serial_out_c,
  output logic                              serial_out_d,
  output logic                              out_word_select,
  output logic                              out_bit_clock
);
  import sapslv_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  logic       bck_q;
  logic       ws_d;
  logic [8:0] pos;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
      bck_q  <= 1'b0;
    end else begin
      sync_a <= {serial_in, port_word_select, port_bit_clock}; // [R1] [R2]
      sync_b <= sync_a;
      bck_q  <= sync_b[0];
    end
  end

  wire       bck_rise = sync_b[0] & ~bck_q; // [R1]
  wire       ws_now   = sync_b[1];
  wire [3:0] din      = sync_b[5:2];
  wire       boundary = bck_rise & (ws_now != ws_d);
  wire       is_i2s   = (cfg_format == SAPSLV_I2S);

  // ----------------------------------------------------------------
  // Word size decode
  // ----------------------------------------------------------------
  wire [4:0] wsz_bits = (cfg_word_size == `SAPSLV_WSZ_16) ? 5'h10 :
                        (cfg_word_size == `SAPSLV_WSZ_18) ? 5'h12 :
                        (cfg_word_size == `SAPSLV_WSZ_20) ? 5'h14 : 5'h18; // [R3] [R11]
  wire [4:0] shift    = 5'h18 - wsz_bits;
  wire [23:0] lsb_mask = 24'hffffff >> shift;

  // Bits since the last word select edge, saturating
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ws_d <= 1'b0;
      pos  <= 9'h000;
    end else if (bck_rise) begin
      ws_d <= ws_now;
      if (boundary)
        pos <= 9'h000; // [R14]
      else if (pos != `SAPSLV_MAX_BCK)
        pos <= pos + 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // Per-input deserialisers
  // ----------------------------------------------------------------
  logic [23:0] ch [8];
  logic        coax_hit;

  for (genvar gi = 0; gi < 4; gi++) begin : g_in
    logic [23:0] acc;
    wire         take    = ({4'h0, wsz_bits} > pos);
    wire [23:0]  shifted = {acc[22:0], din[gi]};
    // I2S: the edge bit is still the previous word's last bit
    wire [23:0]  i2s_raw = take ? shifted : acc; // [R14] [R5]
    wire [23:0]  aligned = is_i2s ? (i2s_raw << shift) : ((acc & lsb_mask) << shift); // [R15]

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        acc <= 24'h000000;
      end else if (bck_rise) begin
        if (is_i2s)
          acc <= boundary ? 24'h000000 : (take ? shifted : acc); // [R5]
        else
          acc <= shifted; // [R15]
      end
    end

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        ch[2*gi]   <= 24'h000000;
        ch[2*gi+1] <= 24'h000000;
      end else if (cfg_coax_mode) begin
        // Serial lanes are silent while a coax source feeds the port
        if (gi == 0 && coax_hit) begin
          ch[0] <= cfg_coax_sel ? coax_b_left  : coax_a_left; // [R9]
          ch[1] <= cfg_coax_sel ? coax_b_right : coax_a_right;
        end else if (gi != 0) begin
          ch[2*gi]   <= 24'h000000;
          ch[2*gi+1] <= 24'h000000;
        end
      end else if (boundary) begin
        if (ws_d)
          ch[2*gi+1] <= aligned; // [R8]
        else
          ch[2*gi]   <= aligned; // [R14]
      end
    end

    assign rx_frame[2*gi]   = ch[2*gi];
    assign rx_frame[2*gi+1] = ch[2*gi+1];
  end

  // ----------------------------------------------------------------
  // Source mode and pin sharing
  // ----------------------------------------------------------------
  assign coax_hit = cfg_coax_sel ? coax_b_valid : coax_a_valid; // [R9]

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      coax_receiver_a <= 1'b0;
      coax_receiver_b <= 1'b0;
      rx_frame_valid  <= 1'b0;
    end else begin
      coax_receiver_a <= cfg_coax_mode & din[1]; // [R12]
      coax_receiver_b <= cfg_coax_mode & din[2]; // [R12]
      rx_frame_valid  <= cfg_coax_mode ? coax_hit : (boundary & ws_d); // [R10]
    end
  end

  assign stream_dac_left  = ch[0];
  assign stream_dac_right = ch[1];

  // ----------------------------------------------------------------
  // Output port, master of its own bit clock
  // ----------------------------------------------------------------
  logic [7:0]       div_cnt;
  logic [5:0]       slot;
  sapslv_frame_type tx_hold;

  wire div_end  = (div_cnt == 8'(OUT_HALF_DIV - 1));
  wire bck_fall = div_end & out_bit_clock;
  wire [5:0] next_slot = slot + 6'h01;
  wire [4:0] bitp   = next_slot[4:0];
  wire       next_ch = next_slot[5];
  wire [4:0] bit_ix = 5'h17 - bitp;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt       <= 8'h00;
      out_bit_clock <= 1'b0;
    end else begin
      div_cnt       <= div_end ? 8'h00 : div_cnt + 8'h01;
      out_bit_clock <= div_end ? ~out_bit_clock : out_bit_clock; // [R13]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slot            <= 6'h3f;
      tx_hold         <= '0;
      out_word_select <= 1'b0;
      {serial_out_a, serial_out_b, serial_out_c, serial_out_d} <= 4'h0;
    end else if (bck_fall) begin
      slot            <= next_slot;
      out_word_select <= (6'(next_slot + 6'h01) >= `SAPSLV_SLOT_BITS); // [R13]
      if (next_slot == 6'h3f)
        tx_hold <= tx_frame;
      if (bitp < 5'h18) begin
        serial_out_a <= tx_hold[{2'h0, next_ch}][bit_ix];
        serial_out_b <= tx_hold[{2'h1, next_ch}][bit_ix];
        serial_out_c <= tx_hold[{2'h2, next_ch}][bit_ix];
        serial_out_d <= tx_hold[{2'h3, next_ch}][bit_ix];
      end else begin
        {serial_out_a, serial_out_b, serial_out_c, serial_out_d} <= 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_edge_from_pin: assert property (boundary |-> $past(bck_q) == 1'b0 && sync_b[0]) // [R1]
    else $error("word edge taken without input bit clock rise");
  a_pos_restart: assert property (boundary |=> pos == 9'h000) // [R14]
    else $error("bit position not restarted at word edge");
  a_pos_count: assert property (bck_rise && !boundary && pos < 9'h0ff
                                |=> pos == $past(pos) + 9'h001) // [R6]
    else $error("bit position did not advance");
  a_frame_pulse: assert property (rx_frame_valid && !cfg_coax_mode |=> !rx_frame_valid) // [R8]
    else $error("frame strobe longer than one cycle");
  a_lsb_align: assert property (boundary && !is_i2s && !cfg_coax_mode
                                && cfg_word_size == `SAPSLV_WSZ_24 && !ws_d
                                |=> ch[0] == $past(g_in[0].acc)) // [R15]
    else $error("LSB-justified left word misaligned");
  a_truncate: assert property (bck_rise && !boundary && is_i2s && pos >= 9'h018
                               |=> $stable(g_in[0].acc)) // [R5]
    else $error("I2S bits beyond 24 were kept");
  a_coax_silent: assert property (cfg_coax_mode ##1 cfg_coax_mode |-> ch[7] == 24'h000000) // [R9]
    else $error("serial lane active in coax mode");
  a_pin_route: assert property (##1 coax_receiver_a == ($past(cfg_coax_mode) & $past(din[1]))) // [R12]
    else $error("coax receiver pin not routed");
  a_out_ws: assert property (bck_fall |=> out_word_select ==
                             (slot > 6'h1e && slot < 6'h3f)) // [R13]
    else $error("output word select off its slot");
  a_out_bck_hold: assert property ($rose(out_bit_clock) |-> out_bit_clock [*2]) // [R13]
    else $error("output bit clock pulse too short");

  c_serial_frame: cover property (rx_frame_valid && !cfg_coax_mode && is_i2s);
  c_lsb_frame: cover property (rx_frame_valid && !cfg_coax_mode && !is_i2s);
  c_coax_frame: cover property (rx_frame_valid && cfg_coax_mode && cfg_coax_sel);
  c_out_wrap: cover property (bck_fall && slot == 6'h3e);
endmodule

// File: dv/sapslv_source.sv
// Purpose: Audio source model, master of bit clock and word select
// Assumes: 125 ns bit clock that runs only inside frames
// Notes:   Idle data lines show the inverse of their last bits
`timescale 1ns/1ps
module sapslv_source (
  output logic       port_bit_clock,
  output logic       port_word_select,
  output logic [3:0] serial_in
);
  logic [3:0] prev;
  logic [3:0] cur;
  initial begin
    port_bit_clock = 1'b0;
    port_word_select = 1'b1;
    serial_in = 4'h0;
    prev = 4'h0;
  end
  // ----------------------------------------
  // Frame tasks
  // ----------------------------------------
  task automatic send(input logic [7:0][31:0] w, input bit lsbj, input int len, input int half);
    int j;
    for (int h = 0; h < 2; h++) begin
      for (int k = 0; k < half; k++) begin
        j = lsbj ? k - half + len : k;
        for (int l = 0; l < 4; l++) begin
          cur[l] = (j >= 0 && j < len) ? w[2*l+h][31-j] : 1'b0;
        end
        port_word_select = h[0];
        // I2S lags one bit behind the word select change
        serial_in = lsbj ? cur : prev;
        prev = cur;
        #62.5 port_bit_clock = 1'b1;
        #62.5 port_bit_clock = 1'b0;
      end
    end
  endtask
  task automatic set_lines(input logic [3:0] v);
    serial_in <= v;
  endtask
  task automatic release_lines();
    serial_in = ~serial_in;
  endtask
endmodule

// File: dv/serial_audio_port_slave_test.sv
// Purpose: Self-checking bench of the serial audio slave port
// Assumes: Output bit clock divider of 2 to keep output frames short
// Notes:   Received frames are matched from the tail of the queue
`timescale 1ns/1ps
module serial_audio_port_slave_test;
  import sapslv_pkg::*;
  logic              clock, rst_n, port_bit_clock, port_word_select;
  logic              cfg_coax_mode, cfg_coax_sel, coax_a_valid, coax_b_valid;
  logic              coax_receiver_a, coax_receiver_b, rx_frame_valid;
  logic              out_word_select, out_bit_clock, obk_q, ows_q;
  logic [3:0]        serial_in;
  logic [1:0]        cfg_word_size;
  sapslv_format_type cfg_format;
  sapslv_sample_type coax_a_left, coax_a_right, coax_b_left, coax_b_right;
  sapslv_sample_type stream_dac_left, stream_dac_right;
  sapslv_frame_type  rx_frame, tx_frame, got_q[$], exp_q[$];
  logic [31:0]       sh [4];
  wire logic [3:0]   lane;
  int                err_total, checked, out_frames;
  sapslv_top #(.OUT_HALF_DIV(2)) sapslv_top_i (.clock(clock), .rst_n(rst_n),
    .port_bit_clock(port_bit_clock), .port_word_select(port_word_select),
    .serial_in(serial_in), .cfg_coax_mode(cfg_coax_mode), .cfg_coax_sel(cfg_coax_sel),
    .cfg_format(cfg_format), .cfg_word_size(cfg_word_size), .coax_a_left(coax_a_left),
    .coax_a_right(coax_a_right), .coax_a_valid(coax_a_valid), .coax_b_left(coax_b_left),
    .coax_b_right(coax_b_right), .coax_b_valid(coax_b_valid),
    .coax_receiver_a(coax_receiver_a), .coax_receiver_b(coax_receiver_b),
    .rx_frame(rx_frame), .rx_frame_valid(rx_frame_valid),
    .stream_dac_left(stream_dac_left), .stream_dac_right(stream_dac_right),
    .tx_frame(tx_frame), .serial_out_a(lane[0]), .serial_out_b(lane[1]),
    .serial_out_c(lane[2]), .serial_out_d(lane[3]),
    .out_word_select(out_word_select), .out_bit_clock(out_bit_clock));
  sapslv_source sapslv_source_i (.port_bit_clock(port_bit_clock),
    .port_word_select(port_word_select), .serial_in(serial_in));
  // ----------------------------------------
  // Checks and monitors
  // ----------------------------------------
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t ns: got %h, want %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock) begin
    if (rx_frame_valid === 1'b1) got_q.push_back(rx_frame);
    obk_q <= out_bit_clock;
    if (rst_n && out_bit_clock && !obk_q) begin
      ows_q <= out_word_select;
      for (int l = 0; l < 4; l++) sh[l] = {sh[l][30:0], lane[l]};
      // Word select turns one bit clock early, so the word just ended sits in the top bits
      if (out_word_select !== ows_q) begin
        out_frames++;
        for (int l = 0; l < 4; l++)
          if (out_frames > 4) chk(sh[l][31:8], tx_frame[2*l+32'(!out_word_select)]);
      end
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic run_serial(input bit lsbj, input int c, input int len, input int half);
    logic [7:0][31:0] w;
    sapslv_frame_type e;
    int               n;
    @(posedge clock);
    cfg_format <= lsbj ? SAPSLV_LSBJ : SAPSLV_I2S;
    cfg_word_size <= c[1:0];
    // Keep link edges off the core clock edges
    #1;
    for (int f = 0; f < 3; f++) begin
      for (int i = 0; i < 8; i++) begin
        w[i] = $urandom;
        e[i] = w[i][31:8] & (24'hffffff << (c == 3 ? 0 : 8 - 2 * c));
      end
      if (f > 0) exp_q.push_back(e);
      sapslv_source_i.send(w, lsbj, len, f == 2 ? half : 48);
    end
    sapslv_source_i.send(w, lsbj, len, 1);
    sapslv_source_i.release_lines();
    repeat (8) @(posedge clock);
    n = got_q.size();
    for (int f = 0; f < 2; f++)
      for (int i = 0; i < 8; i++) chk(got_q[n-2+f][i], exp_q[f][i]);
    exp_q.delete();
    $display("serial test done: format %0d size code %0d length %0d", lsbj, c, len);
  endtask
  task automatic run_coax();
    sapslv_frame_type e;
    for (int s = 0; s < 2; s++) begin
      @(posedge clock);
      cfg_coax_mode <= 1'b1;
      cfg_coax_sel <= s[0];
      coax_a_left <= 24'($urandom);
      coax_a_right <= 24'($urandom);
      coax_b_left <= 24'($urandom);
      coax_b_right <= 24'($urandom);
      {coax_a_valid, coax_b_valid} <= 2'h3;
      @(posedge clock);
      {coax_a_valid, coax_b_valid} <= 2'h0;
      e = '0;
      e[0] = s ? coax_b_left : coax_a_left;
      e[1] = s ? coax_b_right : coax_a_right;
      repeat (3) @(posedge clock);
      for (int i = 0; i < 8; i++) chk(got_q[$][i], e[i]);
      chk(stream_dac_left, e[0]);
      chk(stream_dac_right, e[1]);
    end
    for (int v = 0; v < 8; v++) begin
      @(posedge clock);
      cfg_coax_mode <= v[2];
      sapslv_source_i.set_lines({~v[1], v[1], v[0], ~v[0]});
      repeat (6) @(posedge clock);
      chk(24'(coax_receiver_a), 24'(v[2] & v[0]));
      chk(24'(coax_receiver_b), 24'(v[2] & v[1]));
    end
    cfg_coax_mode <= 1'b0;
    $display("coax test done");
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    void'($urandom(27));
    rst_n = 1'b0;
    {cfg_coax_mode, cfg_coax_sel, coax_a_valid, coax_b_valid} = 4'h0;
    {coax_a_left, coax_a_right, coax_b_left, coax_b_right} = '0;
    cfg_format = SAPSLV_I2S;
    cfg_word_size = 2'h3;
    for (int i = 0; i < 8; i++) tx_frame[i] = 24'($urandom);
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    for (int b = 0; b < 2; b++)
      for (int c = 0; c < 4; c++) run_serial(b[0], c, c == 3 ? 24 : 16 + 2 * c, 48 + 8 * c);
    run_serial(1'b0, 3, 32, 125);
    run_coax();
    close_out();
  end
  initial begin
    // About 370 us of frames; margin kept under 90000 clocks
    #450000;
    err_total++;
    close_out();
  end
endmodule
